// ===== dv/input_terminals.sv
// input terminal model fanning one switch pattern out to every gate
`timescale 1ns/1ps
module input_terminals (
  input  gate_timer_pkg::gate_in_t pattern,
  output gate_timer_pkg::gate_in_t conjunctionIn,
  output gate_timer_pkg::gate_in_t boundaryConjunctionIn,
  output gate_timer_pkg::gate_in_t disjunctionIn,
  output logic                     inverterIn,
  output logic [1:0]               exclusiveIn,
  output gate_timer_pkg::gate_in_t negConjunctionIn,
  output gate_timer_pkg::gate_in_t boundaryNegConjunctionIn,
  output gate_timer_pkg::gate_in_t negDisjunctionIn,
  output gate_timer_pkg::gate_in_t risingDisjunctionIn,
  output gate_timer_pkg::gate_in_t fallingDisjunctionIn
);
  import gate_timer_pkg::*;
  // every gate sees the same pattern, the inverter only bit 0 and the xor bits 1:0, so one scan exercises all of them
  assign conjunctionIn            = pattern;
  assign boundaryConjunctionIn    = pattern;
  assign disjunctionIn            = pattern;
  assign inverterIn               = pattern[0];
  assign exclusiveIn              = pattern[1:0];
  assign negConjunctionIn         = pattern;
  assign boundaryNegConjunctionIn = pattern;
  assign negDisjunctionIn         = pattern;
  assign risingDisjunctionIn      = pattern;
  assign fallingDisjunctionIn     = pattern;
endmodule

// ===== dv/logic_gates_and_delay_timers_asserts.sv
// concurrent checks on the gate and timer outputs
`timescale 1ns/1ps
module logic_gates_and_delay_timers_asserts (
  input wire logic               clk,
  input wire logic               rstn,
  input wire logic               ce,
  input wire logic               scanGo,
  input wire logic               powerLoss,
  input gate_timer_pkg::gate_in_t conjunctionIn,
  input gate_timer_pkg::gate_in_t disjunctionIn,
  input wire logic               inverterIn,
  input wire logic [1:0]         exclusiveIn,
  input gate_timer_pkg::gate_in_t negConjunctionIn,
  input gate_timer_pkg::gate_in_t negDisjunctionIn,
  input wire logic               onDelayTrig,
  input wire logic               onDelayClear,
  input wire logic               offDelayTrig,
  input wire logic               offDelayClear,
  input wire logic               conjunctionQ,
  input wire logic               disjunctionQ,
  input wire logic               inverterQ,
  input wire logic               exclusiveQ,
  input wire logic               negConjunctionQ,
  input wire logic               negDisjunctionQ,
  input wire logic               onDelayTimerQ,
  input gate_timer_pkg::count_t  onDelayElapsed,
  input wire logic               offDelayTimerQ,
  input gate_timer_pkg::count_t  offDelayElapsed
);
  import gate_timer_pkg::*;
  logic scanAt;
  assign scanAt = ce & scanGo & ~powerLoss;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_and; scanAt |=> conjunctionQ == &$past(conjunctionIn); endproperty
  a_and: assert property (p_and) else $error("and output wrong");
  property p_or; scanAt |=> disjunctionQ == |$past(disjunctionIn); endproperty
  a_or: assert property (p_or) else $error("or output wrong");
  property p_not; scanAt |=> inverterQ != $past(inverterIn); endproperty
  a_not: assert property (p_not) else $error("inverter output wrong");
  property p_xor; scanAt |=> exclusiveQ == ^$past(exclusiveIn); endproperty
  a_xor: assert property (p_xor) else $error("xor output wrong");
  property p_nand; scanAt |=> negConjunctionQ != &$past(negConjunctionIn); endproperty
  a_nand: assert property (p_nand) else $error("nand output wrong");
  property p_nor; scanAt |=> negDisjunctionQ != |$past(negDisjunctionIn); endproperty
  a_nor: assert property (p_nor) else $error("nor output wrong");
  property p_onLow;
    scanAt && (!onDelayTrig || onDelayClear) |=> !onDelayTimerQ && onDelayElapsed == COUNT_ZERO;
  endproperty
  a_onLow: assert property (p_onLow) else $error("on-delay not cleared");
  property p_offClr; scanAt && offDelayClear |=> !offDelayTimerQ ##0 offDelayElapsed == 0;
  endproperty
  a_offClr: assert property (p_offClr) else $error("off-delay clear ignored");
  property p_offHigh;
    scanAt && offDelayTrig && !offDelayClear |=> offDelayTimerQ && offDelayElapsed == 0;
  endproperty
  a_offHigh: assert property (p_offHigh) else $error("off-delay not on");
  property p_hold; !(ce && (scanGo || powerLoss)) |=> $stable(onDelayElapsed) && $stable(conjunctionQ);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved between scans");
endmodule

bind logic_gates_and_delay_timers logic_gates_and_delay_timers_asserts u_asserts (
  .clk(clk), .rstn(rstn), .ce(ce), .scanGo(scanGo), .powerLoss(powerLoss),
  .conjunctionIn(conjunctionIn), .disjunctionIn(disjunctionIn), .inverterIn(inverterIn),
  .exclusiveIn(exclusiveIn), .negConjunctionIn(negConjunctionIn),
  .negDisjunctionIn(negDisjunctionIn), .onDelayTrig(onDelayTrig), .onDelayClear(onDelayClear),
  .offDelayTrig(offDelayTrig), .offDelayClear(offDelayClear), .conjunctionQ(conjunctionQ),
  .disjunctionQ(disjunctionQ), .inverterQ(inverterQ), .exclusiveQ(exclusiveQ),
  .negConjunctionQ(negConjunctionQ), .negDisjunctionQ(negDisjunctionQ),
  .onDelayTimerQ(onDelayTimerQ), .onDelayElapsed(onDelayElapsed),
  .offDelayTimerQ(offDelayTimerQ), .offDelayElapsed(offDelayElapsed));

// ===== dv/testbench.sv
// self-checking bench for the scan gates and delay timers
`timescale 1ns/1ps
module testbench;
  import gate_timer_pkg::*;
  logic clk, rstn, ce, scanGo, powerLoss, odTrig, odClear, odRetain, ofTrig, ofClear;
  gate_in_t pattern, prev, cIn, bcIn, dIn, ncIn, bncIn, ndIn, rdIn, fdIn;
  logic invIn;
  logic [1:0] xIn;
  logic [5:0] odSec, ofSec;
  logic [9:0] odMs, ofMs;
  logic cQ, bcQ, dQ, iQ, xQ, ncQ, bncQ, ndQ, rQ, fQ, onQ, offQ;
  count_t onEl, offEl;
  int err_count, n_tests;

  input_terminals u_terms (.pattern(pattern), .conjunctionIn(cIn), .boundaryConjunctionIn(bcIn),
    .disjunctionIn(dIn), .inverterIn(invIn), .exclusiveIn(xIn), .negConjunctionIn(ncIn),
    .boundaryNegConjunctionIn(bncIn), .negDisjunctionIn(ndIn), .risingDisjunctionIn(rdIn),
    .fallingDisjunctionIn(fdIn));
  logic_gates_and_delay_timers #(.TickCycles(10)) u_dut (.clk(clk), .rstn(rstn), .ce(ce),
    .scanGo(scanGo), .powerLoss(powerLoss), .conjunctionIn(cIn), .boundaryConjunctionIn(bcIn),
    .disjunctionIn(dIn), .inverterIn(invIn), .exclusiveIn(xIn), .negConjunctionIn(ncIn),
    .boundaryNegConjunctionIn(bncIn), .negDisjunctionIn(ndIn), .risingDisjunctionIn(rdIn),
    .fallingDisjunctionIn(fdIn), .onDelayTrig(odTrig), .onDelayClear(odClear),
    .onDelayRetain(odRetain), .onDelayHours(10'h000), .onDelayMinutes(6'h00),
    .onDelaySeconds(odSec), .onDelayMillis(odMs), .offDelayTrig(ofTrig),
    .offDelayClear(ofClear), .offDelayHours(10'h000), .offDelayMinutes(6'h00),
    .offDelaySeconds(ofSec), .offDelayMillis(ofMs), .conjunctionQ(cQ),
    .boundaryConjunctionQ(bcQ), .disjunctionQ(dQ), .inverterQ(iQ), .exclusiveQ(xQ),
    .negConjunctionQ(ncQ), .boundaryNegConjunctionQ(bncQ), .negDisjunctionQ(ndQ),
    .risingDisjunctionQ(rQ), .fallingDisjunctionQ(fQ), .onDelayTimerQ(onQ),
    .onDelayElapsed(onEl), .offDelayTimerQ(offQ), .offDelayElapsed(offEl));

  task automatic chkBit(input string what, input logic expv, input logic got);
    n_tests++;
    if (got !== expv) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", what, expv, got);
    end
  endtask
  task automatic chkCnt(input string what, input count_t expv, input count_t got);
    n_tests++;
    if (got !== expv) begin
      err_count++;
      $display("ERROR %s expected %0d seen %0d", what, expv, got);
    end
  endtask
  task automatic scan(input gate_in_t p);
    @(posedge clk);
    #1;
    pattern = p;
    scanGo = 1'b1;
    @(posedge clk);
    #1;
    scanGo = 1'b0;
  endtask
  // two durations of 20 ms at 10 cycles per tick leave at least one tick between scans
  task automatic gap();
    repeat (12) @(posedge clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_gates();
    gate_in_t tbl [10] = '{8'h00, 8'hFF, 8'hFF, 8'h7F, 8'h01, 8'h00, 8'hAA, 8'h55, 8'hFF, 8'hFE};
    gate_in_t p;
    prev = 8'h00;
    foreach (tbl[i]) begin
      p = tbl[i];
      scan(p);
      chkBit("and", &p, cQ);
      chkBit("boundary and", &p & ~&prev, bcQ);
      chkBit("or", |p, dQ);
      chkBit("not", ~p[0], iQ);
      chkBit("xor", ^p[1:0], xQ);
      chkBit("nand", ~&p, ncQ);
      chkBit("boundary nand", ~&p & &prev, bncQ);
      chkBit("nor", ~|p, ndQ);
      chkBit("rising or", |(p & ~prev), rQ);
      chkBit("falling or", |(~p & prev), fQ);
      prev = p;
    end
    ce = 1'b0;
    scan(8'hFF);
    chkBit("and frozen", 1'b0, cQ);
    ce = 1'b1;
  endtask
  task automatic t_on_delay();
    odTrig = 1'b1;
    scan(pattern);
    chkCnt("on elapsed at rise", 0, onEl);
    gap();
    scan(pattern);
    chkCnt("on elapsed one tick", 1, onEl);
    chkBit("on q early", 1'b0, onQ);
    gap();
    scan(pattern);
    chkBit("on q expired", 1'b1, onQ);
    chkCnt("on elapsed full", 2, onEl);
    odTrig = 1'b0;
    scan(pattern);
    chkBit("on q trig low", 1'b0, onQ);
    odTrig = 1'b1;
    scan(pattern);
    gap();
    scan(pattern);
    odTrig = 1'b0;
    scan(pattern);
    chkCnt("on elapsed early drop", 0, onEl);
    odTrig = 1'b1;
    scan(pattern);
    gap();
    odClear = 1'b1;
    scan(pattern);
    chkCnt("on elapsed cleared", 0, onEl);
    odClear = 1'b0;
    gap();
    scan(pattern);
    chkCnt("on no restart", 0, onEl);
    chkBit("on q after clear", 1'b0, onQ);
    // a setting below one tick still runs for one tick
    odMs = 10'h005;
    odTrig = 1'b0;
    scan(pattern);
    odTrig = 1'b1;
    scan(pattern);
    gap();
    scan(pattern);
    chkBit("on q min duration", 1'b1, onQ);
    chkCnt("on elapsed min duration", 1, onEl);
    odMs = 10'h014;
  endtask
  task automatic t_retain();
    odTrig = 1'b0;
    scan(8'h01);
    odTrig = 1'b1;
    odRetain = 1'b1;
    scan(8'h01);
    gap();
    scan(8'h01);
    @(posedge clk);
    #1;
    powerLoss = 1'b1;
    @(posedge clk);
    #1;
    powerLoss = 1'b0;
    chkCnt("on retained", 1, onEl);
    chkBit("or after power loss", 1'b0, dQ);
  endtask
  task automatic t_off_delay();
    ofTrig = 1'b1;
    scan(pattern);
    chkBit("off q trig high", 1'b1, offQ);
    ofTrig = 1'b0;
    scan(pattern);
    chkBit("off q after fall", 1'b1, offQ);
    gap();
    scan(pattern);
    gap();
    scan(pattern);
    chkBit("off q expired", 1'b0, offQ);
    chkCnt("off elapsed expired", 0, offEl);
    ofTrig = 1'b1;
    ofClear = 1'b1;
    scan(pattern);
    chkBit("off q clear wins", 1'b0, offQ);
    ofClear = 1'b0;
    scan(pattern);
    chkBit("off q back on", 1'b1, offQ);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
  initial begin
    {scanGo, powerLoss, odTrig, odClear, odRetain, ofTrig, ofClear} = '0;
    ce = 1'b1;
    pattern = 8'h00;
    {odSec, ofSec} = '0;
    {odMs, ofMs} = {10'h014, 10'h014};
    err_count = 0;
    n_tests = 0;
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (2) @(posedge clk);
    t_gates();
    t_on_delay();
    t_off_delay();
    t_retain();
    end_of_test();
  end
endmodule

// ===== rtl/duration_reg.sv
// converts a h:m:s:ms setting into a registered count of 10 ms ticks
`timescale 1ns/1ps
module duration_reg (
  input  wire logic                                  clk,
  input  wire logic                                  rstn,
  input  wire logic                                  ce,
  input  wire logic [gate_timer_pkg::HOUR_WIDTH-1:0] hours,
  input  wire logic [gate_timer_pkg::MIN_WIDTH-1:0]  minutes,
  input  wire logic [gate_timer_pkg::SEC_WIDTH-1:0]  seconds,
  input  wire logic [gate_timer_pkg::MS_WIDTH-1:0]   millis,
  output gate_timer_pkg::count_t                     ticks
);
  import gate_timer_pkg::*;

  typedef struct packed {
    count_t ticks;
  } dur_state_t;

  dur_state_t r_q;
  dur_state_t r_d;

  always_comb begin
    r_d       = r_q;
    r_d.ticks = toTicks(hours, minutes, seconds, millis);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_q <= dur_state_t'(MIN_TICKS);
    end else if (ce) begin
      r_q <= r_d;
    end
  end

  assign ticks = r_q.ticks;
endmodule

// ===== rtl/gate_timer_pkg.sv
// constants, types and shared helpers for the scan gates and delay timers
package gate_timer_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int GATE_WIDTH  = 8;
  localparam int COUNT_WIDTH = 32;
  localparam int HOUR_WIDTH  = 10;
  localparam int MIN_WIDTH   = 6;
  localparam int SEC_WIDTH   = 6;
  localparam int MS_WIDTH    = 10;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TICK_PERIOD_MS = 10;
  localparam int NS_PER_MS      = 1000000;
  localparam int TICK_CYCLES    = TICK_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int MS_PER_SEC     = 1000;
  localparam int TICKS_PER_SEC  = MS_PER_SEC / TICK_PERIOD_MS;
  localparam int SEC_PER_MIN    = 60;
  localparam int MIN_PER_HOUR   = 60;
  localparam int MAX_HOURS      = 999;
  localparam int MAX_MINUTES    = 59;
  localparam int MAX_SECONDS    = 59;
  localparam int MAX_MILLIS     = 990;
  localparam int MIN_TICKS      = 1;

  // ---------------------------------------------------------------
  // retention budget
  // ---------------------------------------------------------------
  localparam int MAX_RETENTIVE  = 16;
  localparam int RETENTIVE_USED = 1;

  typedef logic [COUNT_WIDTH-1:0] count_t;
  typedef logic [GATE_WIDTH-1:0]  gate_in_t;
  typedef enum logic [1:0] {TM_IDLE, TM_RUN, TM_DONE} timer_state_t;

  localparam count_t COUNT_ZERO = 32'h0000_0000;
  localparam count_t COUNT_ONE  = 32'h0000_0001;

  // total delay in 10 ms ticks, each field clamped, never below one tick
  function automatic count_t toTicks(input logic [HOUR_WIDTH-1:0] h,
                                     input logic [MIN_WIDTH-1:0]  m,
                                     input logic [SEC_WIDTH-1:0]  s,
                                     input logic [MS_WIDTH-1:0]   ms);
    int hc;
    int mc;
    int sc;
    int msc;
    int total;
    hc    = (int'(h) > MAX_HOURS) ? MAX_HOURS : int'(h);
    mc    = (int'(m) > MAX_MINUTES) ? MAX_MINUTES : int'(m);
    sc    = (int'(s) > MAX_SECONDS) ? MAX_SECONDS : int'(s);
    msc   = (int'(ms) > MAX_MILLIS) ? MAX_MILLIS : int'(ms);
    total = ((hc * MIN_PER_HOUR + mc) * SEC_PER_MIN + sc) * TICKS_PER_SEC
            + msc / TICK_PERIOD_MS;
    if (total < MIN_TICKS) begin
      total = MIN_TICKS;
    end
    return count_t'(total);
  endfunction

endpackage

// ===== rtl/logic_gates_and_delay_timers.sv
// scan-evaluated logic gates with on-delay and off-delay timers
`timescale 1ns/1ps
module logic_gates_and_delay_timers #(
  parameter int TickCycles = gate_timer_pkg::TICK_CYCLES
) (
  input  wire logic                                  clk,
  input  wire logic                                  rstn,
  input  wire logic                                  ce,
  input  wire logic                                  scanGo,
  input  wire logic                                  powerLoss,
  input  gate_timer_pkg::gate_in_t                   conjunctionIn,
  input  gate_timer_pkg::gate_in_t                   boundaryConjunctionIn,
  input  gate_timer_pkg::gate_in_t                   disjunctionIn,
  input  wire logic                                  inverterIn,
  input  wire logic [1:0]                            exclusiveIn,
  input  gate_timer_pkg::gate_in_t                   negConjunctionIn,
  input  gate_timer_pkg::gate_in_t                   boundaryNegConjunctionIn,
  input  gate_timer_pkg::gate_in_t                   negDisjunctionIn,
  input  gate_timer_pkg::gate_in_t                   risingDisjunctionIn,
  input  gate_timer_pkg::gate_in_t                   fallingDisjunctionIn,
  input  wire logic                                  onDelayTrig,
  input  wire logic                                  onDelayClear,
  input  wire logic                                  onDelayRetain,
  input  wire logic [gate_timer_pkg::HOUR_WIDTH-1:0] onDelayHours,
  input  wire logic [gate_timer_pkg::MIN_WIDTH-1:0]  onDelayMinutes,
  input  wire logic [gate_timer_pkg::SEC_WIDTH-1:0]  onDelaySeconds,
  input  wire logic [gate_timer_pkg::MS_WIDTH-1:0]   onDelayMillis,
  input  wire logic                                  offDelayTrig,
  input  wire logic                                  offDelayClear,
  input  wire logic [gate_timer_pkg::HOUR_WIDTH-1:0] offDelayHours,
  input  wire logic [gate_timer_pkg::MIN_WIDTH-1:0]  offDelayMinutes,
  input  wire logic [gate_timer_pkg::SEC_WIDTH-1:0]  offDelaySeconds,
  input  wire logic [gate_timer_pkg::MS_WIDTH-1:0]   offDelayMillis,
  output logic                                       conjunctionQ,
  output logic                                       boundaryConjunctionQ,
  output logic                                       disjunctionQ,
  output logic                                       inverterQ,
  output logic                                       exclusiveQ,
  output logic                                       negConjunctionQ,
  output logic                                       boundaryNegConjunctionQ,
  output logic                                       negDisjunctionQ,
  output logic                                       risingDisjunctionQ,
  output logic                                       fallingDisjunctionQ,
  output logic                                       onDelayTimerQ,
  output gate_timer_pkg::count_t                     onDelayElapsed,
  output logic                                       offDelayTimerQ,
  output gate_timer_pkg::count_t                     offDelayElapsed
);
  import gate_timer_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic allHigh(input gate_in_t v);
    return &v;
  endfunction

  function automatic logic anyHigh(input gate_in_t v);
    return |v;
  endfunction

  function automatic logic reached(input count_t cnt, input count_t dur);
    return cnt >= dur;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic         conjQ;
    logic         bConjQ;
    logic         disjQ;
    logic         invQ;
    logic         xorQ;
    logic         nConjQ;
    logic         bnConjQ;
    logic         nDisjQ;
    logic         riseQ;
    logic         fallQ;
    gate_in_t     bConjPrev;
    gate_in_t     bnConjPrev;
    gate_in_t     risePrev;
    gate_in_t     fallPrev;
    logic         tickPend;
    logic         onPrev;
    timer_state_t onState;
    count_t       onCount;
    logic         onQ;
    logic         offPrev;
    timer_state_t offState;
    count_t       offCount;
    logic         offQ;
  } core_state_t;

  core_state_t r_q;
  core_state_t r_d;

  timebase_if tb ();
  count_t     onDur;
  count_t     offDur;
  logic       advance;
  logic       retainOk;

  assign tb.ce = ce;

  // ---------------------------------------------------------------
  // time base and durations
  // ---------------------------------------------------------------
  tick_gen #(
    .TickCycles (TickCycles)
  ) u_tick (
    .clk  (clk),
    .rstn (rstn),
    .tb   (tb.gen)
  );

  duration_reg u_on_dur (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (ce),
    .hours   (onDelayHours),
    .minutes (onDelayMinutes),
    .seconds (onDelaySeconds),
    .millis  (onDelayMillis),
    .ticks   (onDur)
  );

  duration_reg u_off_dur (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (ce),
    .hours   (offDelayHours),
    .minutes (offDelayMinutes),
    .seconds (offDelaySeconds),
    .millis  (offDelayMillis),
    .ticks   (offDur)
  );

  assign advance = r_q.tickPend | tb.tick;

  assign retainOk = onDelayRetain && (RETENTIVE_USED <= MAX_RETENTIVE);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    r_d = r_q;

    // a tick landing on the scan is consumed by that scan
    if (tb.tick) begin
      r_d.tickPend = 1'b1;
    end

    if (scanGo) begin
      r_d.tickPend = 1'b0;

      r_d.conjQ = allHigh(conjunctionIn);

      // all high now, some low last scan
      r_d.bConjQ = allHigh(boundaryConjunctionIn) && !allHigh(r_q.bConjPrev);

      r_d.disjQ = anyHigh(disjunctionIn);

      r_d.invQ = ~inverterIn;

      r_d.xorQ = exclusiveIn[0] ^ exclusiveIn[1];

      r_d.nConjQ = !allHigh(negConjunctionIn);

      // some low now, all high last scan
      r_d.bnConjQ = !allHigh(boundaryNegConjunctionIn) && allHigh(r_q.bnConjPrev);

      r_d.nDisjQ = !anyHigh(negDisjunctionIn);

      // any bit went 0 to 1
      r_d.riseQ = anyHigh(risingDisjunctionIn & ~r_q.risePrev);

      // any bit went 1 to 0
      r_d.fallQ = anyHigh(~fallingDisjunctionIn & r_q.fallPrev);

      r_d.bConjPrev  = boundaryConjunctionIn;
      r_d.bnConjPrev = boundaryNegConjunctionIn;
      r_d.risePrev   = risingDisjunctionIn;
      r_d.fallPrev   = fallingDisjunctionIn;

      // ---------------- on-delay timer ----------------
      r_d.onPrev = onDelayTrig;
      if (onDelayClear) begin
        r_d.onState = TM_IDLE;
        r_d.onCount = COUNT_ZERO;
        r_d.onQ     = 1'b0;
      end else if (!onDelayTrig) begin
        r_d.onState = TM_IDLE;
        r_d.onCount = COUNT_ZERO;
        r_d.onQ     = 1'b0;
      end else begin
        case (r_q.onState)
          TM_IDLE: begin
            if (!r_q.onPrev) begin
              r_d.onState = TM_RUN;
              r_d.onCount = COUNT_ZERO;
            end
          end
          TM_RUN: begin
            if (advance) begin
              r_d.onCount = r_q.onCount + COUNT_ONE;
            end
            if (reached(r_d.onCount, onDur)) begin
              r_d.onState = TM_DONE;
              r_d.onQ     = 1'b1;
            end
          end
          TM_DONE: begin
            r_d.onQ = 1'b1;
          end
          default: begin
            r_d.onState = TM_IDLE;
            r_d.onCount = COUNT_ZERO;
            r_d.onQ     = 1'b0;
          end
        endcase
      end

      // ---------------- off-delay timer ----------------
      r_d.offPrev = offDelayTrig;
      if (offDelayClear) begin
        r_d.offState = TM_IDLE;
        r_d.offCount = COUNT_ZERO;
        r_d.offQ     = 1'b0;
      end else if (offDelayTrig) begin
        r_d.offState = TM_IDLE;
        r_d.offCount = COUNT_ZERO;
        r_d.offQ     = 1'b1;
      end else begin
        case (r_q.offState)
          TM_IDLE: begin
            if (r_q.offPrev) begin
              r_d.offState = TM_RUN;
              r_d.offCount = COUNT_ZERO;
              r_d.offQ     = 1'b1;
            end
          end
          TM_RUN: begin
            if (advance) begin
              r_d.offCount = r_q.offCount + COUNT_ONE;
            end
            if (reached(r_d.offCount, offDur)) begin
              r_d.offState = TM_IDLE;
              r_d.offCount = COUNT_ZERO;
              r_d.offQ     = 1'b0;
            end
          end
          default: begin
            r_d.offState = TM_IDLE;
            r_d.offCount = COUNT_ZERO;
            r_d.offQ     = 1'b0;
          end
        endcase
      end
    end

    // ---------------- power loss ----------------
    if (powerLoss) begin
      r_d.conjQ      = 1'b0;
      r_d.bConjQ     = 1'b0;
      r_d.disjQ      = 1'b0;
      r_d.invQ       = 1'b0;
      r_d.xorQ       = 1'b0;
      r_d.nConjQ     = 1'b0;
      r_d.bnConjQ    = 1'b0;
      r_d.nDisjQ     = 1'b0;
      r_d.riseQ      = 1'b0;
      r_d.fallQ      = 1'b0;
      r_d.bConjPrev  = '0;
      r_d.bnConjPrev = '0;
      r_d.risePrev   = '0;
      r_d.fallPrev   = '0;
      r_d.tickPend   = 1'b0;
      r_d.offPrev    = 1'b0;
      r_d.offState   = TM_IDLE;
      r_d.offCount   = COUNT_ZERO;
      r_d.offQ       = 1'b0;
      // retentive on-delay resumes from held count
      if (retainOk) begin
        r_d.onPrev  = r_q.onPrev;
        r_d.onState = r_q.onState;
        r_d.onCount = r_q.onCount;
        r_d.onQ     = r_q.onQ;
      end else begin
        r_d.onPrev  = 1'b0;
        r_d.onState = TM_IDLE;
        r_d.onCount = COUNT_ZERO;
        r_d.onQ     = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_q <= '0;
    end else if (ce) begin
      r_q <= r_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign conjunctionQ            = r_q.conjQ;
  assign boundaryConjunctionQ    = r_q.bConjQ;
  assign disjunctionQ            = r_q.disjQ;
  assign inverterQ               = r_q.invQ;
  assign exclusiveQ              = r_q.xorQ;
  assign negConjunctionQ         = r_q.nConjQ;
  assign boundaryNegConjunctionQ = r_q.bnConjQ;
  assign negDisjunctionQ         = r_q.nDisjQ;
  assign risingDisjunctionQ      = r_q.riseQ;
  assign fallingDisjunctionQ     = r_q.fallQ;
  assign onDelayTimerQ           = r_q.onQ;
  assign offDelayTimerQ          = r_q.offQ;

  assign onDelayElapsed  = r_q.onCount;
  assign offDelayElapsed = r_q.offCount;

endmodule

// ===== rtl/tick_gen.sv
// 10 ms time base derived from the system clock
`timescale 1ns/1ps
module tick_gen #(
  parameter int TickCycles = gate_timer_pkg::TICK_CYCLES
) (
  input  wire logic  clk,
  input  wire logic  rstn,
  timebase_if.gen    tb
);
  import gate_timer_pkg::*;

  typedef struct packed {
    count_t cnt;
    logic   tick;
  } tick_state_t;

  tick_state_t r_q;
  tick_state_t r_d;

  always_comb begin
    r_d      = r_q;
    r_d.tick = 1'b0;
    if (r_q.cnt >= count_t'(TickCycles - 1)) begin
      r_d.cnt  = COUNT_ZERO;
      r_d.tick = 1'b1;
    end else begin
      r_d.cnt = r_q.cnt + COUNT_ONE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_q <= '0;
    end else if (tb.ce) begin
      r_q <= r_d;
    end
  end

  assign tb.tick = r_q.tick;
endmodule

// ===== rtl/timebase_if.sv
// time base signals shared between the tick generator and the block core
`timescale 1ns/1ps
interface timebase_if;
  logic ce;
  logic tick;

  modport gen  (input ce, output tick);
  modport core (output ce, input tick);
endinterface
